/* File: dmem_pkg.sv */
`default_nettype none
package dmem_pkg;
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned RAM_BYTES     = 8192;
  localparam int unsigned RAM_AW        = 13;
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_PTR_LO    = 8'h04;
  localparam logic [7:0]  REG_PTR_HI    = 8'h08;
  localparam logic [7:0]  REG_ADDR_HI   = 8'h0c;
  localparam logic [7:0]  REG_CFG       = 8'h10;
  localparam logic [7:0]  REG_INDEX     = 8'h14;
  localparam logic [7:0]  REG_DATA      = 8'h18;
  localparam logic [7:0]  REG_STATUS    = 8'h1c;
  localparam logic [7:0]  REG_PORT_HI   = 8'h20;
  localparam int unsigned CFG_MODE_LSB  = 2;
  localparam logic [1:0]  MODE_INT_ONLY = 2'b00;
  localparam logic [1:0]  MODE_SPLIT_NB = 2'b01;
  localparam int unsigned CTRL_GO       = 0;
  localparam int unsigned CTRL_WRITE    = 1;
  localparam int unsigned CTRL_LONG     = 2;
  localparam int unsigned CTRL_FLASH_EN = 3;
  localparam logic [7:0]  CFG_RESET     = 8'h00;
  localparam logic [7:0]  PORT_LATCH_RESET = 8'hff;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;
  localparam int unsigned EXT_CYCLES    = 4;
endpackage
`default_nettype wire

/* File: dmem_ram.sv */
`default_nettype none
module dmem_ram #(
  parameter int unsigned AW = 13,
  parameter int unsigned DW = 8
) (
  input  wire logic          aclk,    // Clock
  input  wire logic          we,      // Write strobe
  input  wire logic [AW-1:0] addr,    // Word address
  input  wire logic [DW-1:0] wdata,   // Write data
  output logic      [DW-1:0] rdata_r  // Registered read data
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_r <= mem[addr];
  end
endmodule
`default_nettype wire

/* File: dmem_axil_slave.sv */
`default_nettype none
module dmem_axil_slave
  import dmem_pkg::*;
(
  input  wire logic        aclk,       // Clock
  input  wire logic        aresetn,    // Sync reset, low
  input  wire logic [7:0]  awaddr,     // Write address
  input  wire logic        awvalid,    // Write address valid
  output logic             awready,    // Write address ready
  input  wire logic [31:0] wdata,      // Write data
  input  wire logic [3:0]  wstrb,      // Byte strobes
  input  wire logic        wvalid,     // Write data valid
  output logic             wready,     // Write data ready
  output logic [1:0]       bresp,      // Write response
  output logic             bvalid,     // Write response valid
  input  wire logic        bready,     // Write response ready
  input  wire logic [7:0]  araddr,     // Read address
  input  wire logic        arvalid,    // Read address valid
  output logic             arready,    // Read address ready
  output logic [31:0]      rdata,      // Read data
  output logic [1:0]       rresp,      // Read response
  output logic             rvalid,     // Read data valid
  input  wire logic        rready,     // Read data ready
  output logic             wr_stb,     // Register write pulse
  output logic [7:0]       wr_addr,    // Register write address
  output logic [7:0]       wr_data,    // Register write byte
  output logic             rd_stb,     // Register read pulse
  output logic [7:0]       rd_addr,    // Register read address
  input  wire logic [31:0] rd_data,    // Register read value, next cycle
  input  wire logic        rd_err,     // Unmapped read
  input  wire logic        wr_err,     // Unmapped write
  input  wire logic        busy        // Hold off requests
);
  logic [7:0] aw_q;
  logic       aw_have;
  logic [7:0] w_q;
  logic       w_lane;
  logic       w_have;
  logic       rd_pend;
  logic       rd_fire;

  assign awready = aresetn && !aw_have && !bvalid;
  assign wready  = aresetn && !w_have && !bvalid;
  assign arready = aresetn && !rd_pend && !rvalid && !busy && !wr_stb;
  assign rd_fire = arvalid && arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      aw_q    <= 8'h00;
      w_q     <= 8'h00;
      w_lane  <= 1'b0;
      wr_stb  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      wr_stb <= 1'b0;
      if (awvalid && awready) begin
        aw_have <= 1'b1;
        aw_q    <= awaddr;
      end
      if (wvalid && wready) begin
        w_have <= 1'b1;
        w_q    <= wdata[7:0];
        w_lane <= wstrb[0];
      end
      // Bytes not in lane 0 are ignored
      if (aw_have && w_have && !busy && !wr_stb && !rd_pend) begin
        aw_have <= 1'b0;
        w_have  <= 1'b0;
        wr_stb  <= w_lane;
        bvalid  <= 1'b1;
        bresp   <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  assign wr_addr = aw_q;
  assign wr_data = w_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend <= 1'b0;
      rd_stb  <= 1'b0;
      rd_addr <= 8'h00;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else begin
      rd_stb <= rd_fire;
      if (rd_fire) begin
        rd_pend <= 1'b1;
        rd_addr <= araddr;
      end
      if (rd_pend && !rd_stb) begin
        rd_pend <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_data;
        rresp   <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: data_memory_address_mapper.sv */
// Notes on behaviour
// - 8 kB on-chip data RAM sits in the indirect data-move space.
// - Short move: high byte from address-high register, low byte from index.
// - Long move: the full 16-bit pointer is the effective address.
// - Pointer is also reachable as separate upper and lower byte registers.
// - Two mapping modes chosen by config bits 3:2; 10 and 11 act as 00.
// - Mode 00: every move targets on-chip RAM.
// - Mode 00: addresses wrap modulo 8 kB.
// - Mode 01: below 8 kB on-chip, above it off-chip.
// - Mode 01 short move: address-high register decides on or off chip.
// - Mode 01 short off-chip: A[15:8] keep port latch, A[7:0] from index.
// - Mode 01 long off-chip: pointer drives all of A[15:0].
// - Moves hit data RAM, never flash, unless a write move is made with flash writing enabled.
`default_nettype none
module data_memory_address_mapper
  import dmem_pkg::*;
#(
  parameter int unsigned RAM_AW_P = RAM_AW
) (
  input  wire logic        aclk,          // Clock, 250 MHz
  input  wire logic        aresetn,       // Sync reset, low
  input  wire logic [7:0]  s_axi_awaddr,  // Write address
  input  wire logic        s_axi_awvalid, // Write address valid
  output logic             s_axi_awready, // Write address ready
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Byte strobes
  input  wire logic        s_axi_wvalid,  // Write data valid
  output logic             s_axi_wready,  // Write data ready
  output logic [1:0]       s_axi_bresp,   // Write response
  output logic             s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  input  wire logic [7:0]  s_axi_araddr,  // Read address
  input  wire logic        s_axi_arvalid, // Read address valid
  output logic             s_axi_arready, // Read address ready
  output logic [31:0]      s_axi_rdata,   // Read data
  output logic [1:0]       s_axi_rresp,   // Read response
  output logic             s_axi_rvalid,  // Read data valid
  input  wire logic        s_axi_rready,  // Read data ready
  output logic [15:0]      ext_addr_o,    // Address bus pins
  output logic [15:0]      ext_addr_oe,   // Address pin drive enables
  output logic [7:0]       ext_data_o,    // Data bus out
  output logic             ext_data_oe,   // Data bus drive enable
  input  wire logic [7:0]  ext_data_i,    // Data bus in (pin)
  output logic             ext_rd_n,      // Read strobe, low
  output logic             ext_wr_n,      // Write strobe, low
  output logic             flash_wr_stb,  // Move redirected to flash write
  output logic [15:0]      flash_addr,    // Flash write address
  output logic [7:0]       flash_data     // Flash write byte
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RAM  = 2'b01,
    ST_EXT  = 2'b10,
    ST_DONE = 2'b11
  } state_t;

  // Strobes and read path of the register slave
  logic        wr_stb;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        rd_stb;
  logic [7:0]  rd_addr;
  logic [31:0] rd_val_r;
  logic        rd_err_r;
  logic        wr_err;
  logic        busy;

  logic [7:0]  ptr_lo_r;
  logic [7:0]  ptr_hi_r;
  logic [7:0]  addr_high_byte_reg;
  logic [7:0]  mem_iface_config_reg;
  logic [7:0]  index_r;
  logic [7:0]  wbyte_r;
  logic [7:0]  rbyte_r;
  logic [7:0]  port_latch_r;
  logic        flash_en_r;
  logic        last_ext_r;
  state_t      state_r;
  logic        op_wr_r;
  logic        op_long_r;
  logic [15:0] eff_addr_r;
  logic [2:0]  ext_cnt_r;
  logic [7:0]  din_s1_r;
  logic [7:0]  din_s2_r;

  logic [15:0] data_pointer_16;
  logic [15:0] eff_nxt;
  logic        offchip_nxt;
  logic [1:0]  mode;
  logic        go;
  logic        go_wr;
  logic        go_long;
  logic        ram_we;
  logic [7:0]  ram_rdata;
  logic [7:0]  cfg_wr;
  logic [RAM_AW_P-1:0] ram_addr;

  assign data_pointer_16 = {ptr_hi_r, ptr_lo_r};
  assign mode = mem_iface_config_reg[CFG_MODE_LSB +: 2];
  // Busy stalls the bus, so no second go can land mid-move
  assign busy = (state_r != ST_IDLE);

  dmem_axil_slave u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_stb  (wr_stb),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_stb  (rd_stb),
    .rd_addr (rd_addr),
    .rd_data (rd_val_r),
    .rd_err  (rd_err_r),
    .wr_err  (wr_err),
    .busy    (busy)
  );

  // Decoded from the captured address; the live bus may have moved on
  always_comb begin
    case (wr_addr)
      REG_CTRL, REG_PTR_LO, REG_PTR_HI, REG_ADDR_HI, REG_CFG,
      REG_INDEX, REG_DATA, REG_PORT_HI: wr_err = 1'b0;
      default:                          wr_err = 1'b1;
    endcase
  end

  // Software-visible registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_lo_r             <= 8'h00;
      ptr_hi_r             <= 8'h00;
      addr_high_byte_reg   <= 8'h00;
      mem_iface_config_reg <= CFG_RESET;
      index_r              <= 8'h00;
      wbyte_r              <= 8'h00;
      port_latch_r         <= PORT_LATCH_RESET;
      flash_en_r           <= 1'b0;
    end else if (wr_stb) begin
      case (wr_addr)
        REG_PTR_LO:  ptr_lo_r <= wr_data;
        REG_PTR_HI:  ptr_hi_r <= wr_data;
        REG_ADDR_HI: addr_high_byte_reg <= wr_data;
        REG_CFG:     mem_iface_config_reg <= cfg_wr;
        REG_INDEX:   index_r <= wr_data;
        REG_DATA:    wbyte_r <= wr_data;
        REG_PORT_HI: port_latch_r <= wr_data;
        REG_CTRL:    flash_en_r <= wr_data[CTRL_FLASH_EN];
        default:     ptr_lo_r <= ptr_lo_r;
      endcase
    end
  end

  // Only the mode field is writable; the rest reads back as zero
  always_comb begin
    cfg_wr                    = CFG_RESET;
    cfg_wr[CFG_MODE_LSB +: 2] = wr_data[CFG_MODE_LSB +: 2];
  end

  // Go starts a move; the other control bits qualify it
  assign go      = wr_stb && (wr_addr == REG_CTRL) && wr_data[CTRL_GO];
  assign go_wr   = wr_data[CTRL_WRITE];
  assign go_long = wr_data[CTRL_LONG];

  // Effective address and placement of a new move
  always_comb begin
    if (go_long) begin
      eff_nxt = data_pointer_16;
    end else begin
      eff_nxt = {addr_high_byte_reg, index_r};
    end
    case (mode)
      MODE_SPLIT_NB: offchip_nxt = (eff_nxt >= 16'(RAM_BYTES));
      MODE_INT_ONLY: offchip_nxt = 1'b0;
      // Modes 10 and 11 are not built; they behave as on-chip only
      default:       offchip_nxt = 1'b0;
    endcase
  end

  // Move sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r      <= ST_IDLE;
      op_wr_r      <= 1'b0;
      op_long_r    <= 1'b0;
      eff_addr_r   <= 16'h0000;
      ext_cnt_r    <= 3'h0;
      rbyte_r      <= 8'h00;
      last_ext_r   <= 1'b0;
      flash_wr_stb <= 1'b0;
      flash_addr   <= 16'h0000;
      flash_data   <= 8'h00;
    end else begin
      flash_wr_stb <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (go) begin
            op_wr_r    <= go_wr;
            op_long_r  <= go_long;
            eff_addr_r <= eff_nxt;
            last_ext_r <= offchip_nxt;
            // Enable comes from an earlier control write, not this one
            if (go_wr && flash_en_r) begin
              flash_wr_stb <= 1'b1;
              flash_addr   <= eff_nxt;
              flash_data   <= wbyte_r;
              state_r      <= ST_IDLE;
            end else if (offchip_nxt) begin
              ext_cnt_r <= 3'(EXT_CYCLES - 1);
              state_r   <= ST_EXT;
            end else begin
              state_r <= ST_RAM;
            end
          end
        end
        // RAM read data is registered; taken in the next state
        ST_RAM: begin
          state_r <= ST_DONE;
        end
        // Last count: pin data has passed both synchroniser stages
        ST_EXT: begin
          if (ext_cnt_r == 3'h0) begin
            if (!op_wr_r) begin
              rbyte_r <= din_s2_r;
            end
            state_r <= ST_IDLE;
          end else begin
            ext_cnt_r <= ext_cnt_r - 3'h1;
          end
        end
        ST_DONE: begin
          if (!op_wr_r) begin
            rbyte_r <= ram_rdata;
          end
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign ram_we = (state_r == ST_RAM) && op_wr_r;

  // Upper bits dropped, so on-chip space repeats every 8 kB
  assign ram_addr = eff_addr_r[RAM_AW_P-1:0];

  dmem_ram #(
    .AW (RAM_AW_P),
    .DW (8)
  ) u_ram (
    .aclk    (aclk),
    .we      (ram_we),
    .addr    (ram_addr),
    .wdata   (wbyte_r),
    .rdata_r (ram_rdata)
  );

  // Data pins come from outside; two stages before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      din_s1_r <= 8'h00;
      din_s2_r <= 8'h00;
    end else begin
      din_s1_r <= ext_data_i;
      din_s2_r <= din_s1_r;
    end
  end

  // Port pins: only off-chip moves touch them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_addr_o  <= 16'h0000;
      ext_addr_oe <= 16'h0000;
      ext_data_o  <= 8'h00;
      ext_data_oe <= 1'b0;
      ext_rd_n    <= 1'b1;
      ext_wr_n    <= 1'b1;
    end else if (state_r == ST_EXT && ext_cnt_r != 3'h0) begin
      if (op_long_r) begin
        ext_addr_o  <= eff_addr_r;
        ext_addr_oe <= 16'hffff;
      end else begin
        ext_addr_o  <= {port_latch_r, eff_addr_r[7:0]};
        ext_addr_oe <= 16'h00ff;
      end
      ext_data_o  <= wbyte_r;
      ext_data_oe <= op_wr_r;
      ext_rd_n    <= op_wr_r;
      ext_wr_n    <= !op_wr_r;
    end else begin
      // Address value is left as is; only the drivers let go
      ext_addr_oe <= 16'h0000;
      ext_data_oe <= 1'b0;
      ext_rd_n    <= 1'b1;
      ext_wr_n    <= 1'b1;
    end
  end

  // Read mux, answered one cycle after the strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_val_r <= 32'h0000_0000;
      rd_err_r <= 1'b0;
    end else if (rd_stb) begin
      rd_err_r <= 1'b0;
      case (rd_addr)
        REG_CTRL:    rd_val_r <= {28'h0, flash_en_r, 3'h0};
        REG_PTR_LO:  rd_val_r <= {24'h0, ptr_lo_r};
        REG_PTR_HI:  rd_val_r <= {24'h0, ptr_hi_r};
        REG_ADDR_HI: rd_val_r <= {24'h0, addr_high_byte_reg};
        REG_CFG:     rd_val_r <= {24'h0, mem_iface_config_reg};
        REG_INDEX:   rd_val_r <= {24'h0, index_r};
        REG_DATA:    rd_val_r <= {24'h0, rbyte_r};
        REG_STATUS:  rd_val_r <= {30'h0, last_ext_r, busy};
        REG_PORT_HI: rd_val_r <= {24'h0, port_latch_r};
        default: begin
          rd_val_r <= 32'h0000_0000;
          rd_err_r <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: data_memory_address_mapper_chk.sv */
`default_nettype none
module data_memory_address_mapper_chk #(
  parameter int unsigned RAM_AW_P = 13
) (
  input wire logic        aclk,          // Clock
  input wire logic        aresetn,       // Reset, low
  input wire logic        s_axi_arvalid, // Read address valid
  input wire logic        s_axi_arready, // Read address ready
  input wire logic        s_axi_rvalid,  // Read data valid
  input wire logic [15:0] ext_addr_o,    // Address pins
  input wire logic [15:0] ext_addr_oe,   // Address enables
  input wire logic        ext_data_oe,   // Data enable
  input wire logic        ext_rd_n,      // Read strobe, low
  input wire logic        ext_wr_n,      // Write strobe, low
  input wire logic        flash_wr_stb   // Flash write pulse
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence rd_pulse;
    !ext_rd_n [*3] ##1 ext_rd_n;
  endsequence
  sequence wr_pulse;
    !ext_wr_n [*3] ##1 ext_wr_n;
  endsequence
  sequence held_read;
    !ext_rd_n ##1 !ext_rd_n;
  endsequence
  AST_RD_PULSE: assert property ($fell(ext_rd_n) |-> rd_pulse)
    else $error("read strobe length wrong");
  AST_WR_PULSE: assert property ($fell(ext_wr_n) |-> wr_pulse)
    else $error("write strobe length wrong");
  AST_NO_BOTH: assert property (ext_rd_n || ext_wr_n)
    else $error("both strobes low");
  AST_OE_SHAPE: assert property ((!ext_rd_n || !ext_wr_n) |->
    (ext_addr_oe == 16'hffff || ext_addr_oe == 16'h00ff))
    else $error("address enables malformed");
  AST_ADDR_STABLE: assert property (held_read |-> $stable(ext_addr_o))
    else $error("address moved during read");
  AST_LONG_ABOVE: assert property ((!ext_rd_n || !ext_wr_n) && ext_addr_oe == 16'hffff
    |-> int'(ext_addr_o) >= (1 << RAM_AW_P))
    else $error("off-chip access below boundary");
  AST_RD_NO_DOE: assert property (!ext_rd_n |-> !ext_data_oe)
    else $error("data driven during read");
  AST_FLASH_QUIET: assert property (flash_wr_stb |-> ext_rd_n && ext_wr_n)
    else $error("flash write reached port");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |-> ##3 s_axi_rvalid)
    else $error("read answer late");
endmodule
bind data_memory_address_mapper data_memory_address_mapper_chk #(.RAM_AW_P(RAM_AW_P)) chk (
  .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .ext_addr_o,
  .ext_addr_oe, .ext_data_oe, .ext_rd_n, .ext_wr_n, .flash_wr_stb);
`default_nettype wire

/* File: offchip_mem_model.sv */
`default_nettype none
module offchip_mem_model (
  input wire logic        aclk,  // Clock
  input wire logic [15:0] addr,  // Address pins
  input wire logic [7:0]  wdata, // Data from device
  input wire logic        rd_n,  // Read strobe, low
  input wire logic        wr_n,  // Write strobe, low
  output logic     [7:0]  rdata  // Data to device
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h00;
  // Released bus shows the inverse, so a stale capture cannot pass
  always_comb rdata = rd_n ? ~last : mem[addr];
  always @(posedge aclk) begin
    if (!wr_n) mem[addr] <= wdata;
    if (!rd_n) last <= mem[addr];
  end
endmodule
`default_nettype wire

/* File: test_data_memory_address_mapper.sv */
`default_nettype none
module test_data_memory_address_mapper;
  import dmem_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, last_bresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] ext_addr_o, ext_addr_oe, flash_addr, cap_addr, cap_oe, cap_faddr;
  logic [7:0]  ext_data_o, ext_data_i, mem_q, flash_data, cap_fdata;
  logic        ext_data_oe, ext_rd_n, ext_wr_n, flash_wr_stb;
  int          errors = 0, n_compared = 0, n_ext = 0, n_flash = 0;

  data_memory_address_mapper dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_addr_o, .ext_addr_oe, .ext_data_o, .ext_data_oe, .ext_data_i, .ext_rd_n,
    .ext_wr_n, .flash_wr_stb, .flash_addr, .flash_data);
  offchip_mem_model mem (.aclk, .addr(ext_addr_o), .wdata(ext_data_o), .rd_n(ext_rd_n),
    .wr_n(ext_wr_n), .rdata(mem_q));
  // Shared data wire: whoever enables wins
  assign ext_data_i = ext_data_oe ? ext_data_o : mem_q;

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // Sampled on the falling edge, well clear of the registered updates
  always @(negedge aclk) begin
    if (!ext_rd_n || !ext_wr_n) begin
      n_ext++;
      cap_addr = ext_addr_o;
      cap_oe = ext_addr_oe;
    end
    if (flash_wr_stb) begin
      n_flash++;
      cap_faddr = flash_addr;
      cap_fdata = flash_data;
    end
  end

  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Handshakes are judged 1 ns before the edge that completes them
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, da, dw, hb;
    da = 1'b0;
    dw = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      #3;
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      da = da | ha;
      dw = dw | hw;
    end while (!(da && dw));
    do begin
      #3;
      hb = s_axi_bvalid;
      last_bresp = s_axi_bresp;
      @(posedge aclk);
    end while (!hb);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic h;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      #3;
      h = s_axi_arready;
      @(posedge aclk);
    end while (!h);
    s_axi_arvalid <= 1'b0;
    do begin
      #3;
      h = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
    end while (!h);
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check(d, e, m);
  endtask
  // Control byte: bit0 go, bit1 write, bit2 pointer form, bit3 flash
  task automatic mv(input logic [7:0] c);
    logic [31:0] s;
    logic [1:0]  r;
    int          n;
    wr(REG_CTRL, {24'h0, c});
    n = 0;
    do begin
      rd(REG_STATUS, s, r);
      n++;
    end while (s[0] && n < 50);
    check({31'h0, s[0]}, 32'h0, "move finished");
  endtask
  task automatic offchip(input logic e);
    logic [31:0] s;
    logic [1:0]  r;
    rd(REG_STATUS, s, r);
    check({31'h0, s[1]}, {31'h0, e}, "off-chip flag");
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rchk(REG_CFG, 32'h0, "cfg reset");
    rchk(REG_PORT_HI, 32'hff, "port latch reset");
    wr(REG_PTR_LO, 32'hcd);
    wr(REG_PTR_HI, 32'hab);
    check({30'h0, last_bresp}, {30'h0, RESP_OKAY}, "mapped write");
    rchk(REG_PTR_LO, 32'hcd, "pointer low");
    rchk(REG_PTR_HI, 32'hab, "pointer high");
    wr(REG_CFG, 32'hf3);
    rchk(REG_CFG, 32'h0, "cfg non-mode bits");
    rd(8'h40, d, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
    wr(8'h40, 32'h0);
    check({30'h0, last_bresp}, {30'h0, RESP_SLVERR}, "unmapped write");
  endtask
  task automatic t_wrap();
    int n0;
    n0 = n_ext;
    wr(REG_PTR_HI, 32'h20);
    wr(REG_PTR_LO, 32'h34);
    wr(REG_DATA, 32'h5a);
    mv(8'h07);
    wr(REG_ADDR_HI, 32'h60);
    wr(REG_INDEX, 32'h34);
    mv(8'h01);
    rchk(REG_DATA, 32'h5a, "wrapped short read");
    check(n_ext - n0, 0, "port quiet in internal mode");
    offchip(1'b0);
  endtask
  task automatic t_split_long();
    int n0;
    wr(REG_CFG, 32'h04);
    wr(REG_PTR_HI, 32'h34);
    wr(REG_PTR_LO, 32'h56);
    wr(REG_DATA, 32'ha5);
    mv(8'h07);
    check(cap_addr, 32'h3456, "long address");
    check(cap_oe, 32'hffff, "long enables");
    check(mem.mem[16'h3456], 32'ha5, "off-chip byte");
    wr(REG_DATA, 32'h00);
    mv(8'h05);
    rchk(REG_DATA, 32'ha5, "off-chip read back");
    offchip(1'b1);
    n0 = n_ext;
    wr(REG_PTR_HI, 32'h1f);
    wr(REG_PTR_LO, 32'hff);
    mv(8'h07);
    check(n_ext - n0, 0, "top on-chip byte");
  endtask
  task automatic t_split_short();
    int n0;
    wr(REG_PORT_HI, 32'h77);
    wr(REG_ADDR_HI, 32'h30);
    wr(REG_INDEX, 32'h12);
    wr(REG_DATA, 32'h3c);
    mv(8'h03);
    check(cap_addr, 32'h7712, "short address");
    check(cap_oe, 32'h00ff, "short enables");
    check(mem.mem[16'h7712], 32'h3c, "short off-chip byte");
    n0 = n_ext;
    wr(REG_ADDR_HI, 32'h1f);
    mv(8'h03);
    check(n_ext - n0, 0, "short on-chip");
    wr(REG_CFG, 32'h0c);
    wr(REG_ADDR_HI, 32'h30);
    n0 = n_ext;
    mv(8'h03);
    check(n_ext - n0, 0, "mode 11 stays on-chip");
  endtask
  task automatic t_flash();
    int n0;
    wr(REG_CFG, 32'h00);
    wr(REG_PTR_HI, 32'h00);
    wr(REG_PTR_LO, 32'h40);
    wr(REG_DATA, 32'h99);
    mv(8'h07);
    wr(REG_DATA, 32'h66);
    wr(REG_CTRL, 32'h08);
    rchk(REG_CTRL, 32'h08, "flash enable readback");
    n0 = n_flash;
    mv(8'h0f);
    check(n_flash - n0, 1, "one flash pulse");
    check(cap_faddr, 32'h0040, "flash address");
    check(cap_fdata, 32'h66, "flash byte");
    mv(8'h05);
    rchk(REG_DATA, 32'h99, "RAM untouched");
  endtask

  initial begin
    aresetn = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_wrap();
    t_split_long();
    t_split_short();
    t_flash();
    give_verdict();
  end
  initial begin
    #100000;
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule
`default_nettype wire
